// >>> hw/hbs_consts.vh
`ifndef HBS_CONSTS_VH
`define HBS_CONSTS_VH
`define HBS_ADR_CTRL 6'h00
`define HBS_ADR_RESULT 6'h01
`define HBS_ADR_STATUS 6'h02
`define HBS_ADR_SAVE 6'h03
`define HBS_ADR_SPOTIDX 6'h04
`define HBS_ADR_SPOTDATA 6'h05
`define HBS_CTRL_EN 0
`define HBS_CTRL_EXCL 1
`define HBS_CTRL_EXT 2
`define HBS_CTRL_MODE_LO 3
`define HBS_CTRL_INIT 8
`define HBS_RES_PHI 4
`define HBS_RES_PLO 5
`define HBS_RES_SNG 6
`define HBS_RES_ERR 7
`define HBS_ST_ERR 3
`define HBS_ST_DONE 4
`define HBS_SAVE_VALID 8
`define HBS_MODE_SPOT 3'h0
`define HBS_MODE_PARTIAL 3'h1
`define HBS_MODE_SETTING 3'h2
`define HBS_MODE_CORR 3'h3
`define HBS_MODE_BOTH 3'h4
`define HBS_BASE_BINS 4'h9
`define HBS_EXT_BINS 4'he
`define HBS_RCL_LOCS 128
`define HBS_SPOT_CHANS 32
`endif

// >>> hw/hbs_handler_io.v
`timescale 1ns/100ps
`include "hbs_consts.vh"
module hbs_handler_io #(
  parameter SPOT_CHANS = `HBS_SPOT_CHANS,
  parameter RCL_LOCS = `HBS_RCL_LOCS
) (
  // Clock and reset
  input wire core_clk_in,
  input wire sys_rst_in,
  // Wishbone slave
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [7:2] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  output reg [31:0] wb_dat_out,
  output reg wb_ack_out,
  // Local panel
  input wire panel_pol_wr_in,
  input wire panel_pol_pos_in,
  // Handler inputs, active low except trigger
  input wire measure_trigger_input_in,
  input wire key_lock_n_in,
  input wire [6:0] recall_select_input_n_in,
  input wire recall_strobe_input_n_in,
  // Handler outputs, active low
  output reg [13:0] bin_class_output_n_out,
  output reg reject_output_n_out,
  output reg secondary_fail_output_n_out,
  output reg error_output_n_out,
  output reg primary_high_output_n_out,
  output reg primary_low_output_n_out,
  output reg measurement_done_output_n_out,
  output reg index_output_n_out,
  // Toward the measurement engine
  output reg measure_start_out,
  output reg panel_locked_out,
  output reg recall_pulse_out,
  output reg [6:0] recall_code_out,
  output reg restore_spot_out,
  output reg restore_main_out,
  output reg restore_settings_out,
  output reg restore_corr_out,
  output reg keep_corr_state_out,
  output reg [31:0] recall_spot_data_out
);

////////////////////////////////////////////////////////////////////////
// Configuration and state

reg comp_en_reg;
reg excl_reg;
reg ext_reg;
reg [2:0] mode_reg;
reg pol_pos_reg;
reg [7:0] result_reg;
reg busy_reg;
reg rcl_err_reg;
reg rcl_done_reg;
reg [6:0] last_code_reg;
reg [4:0] spot_idx_reg;
// One saved flag per recall location
reg [RCL_LOCS-1:0] saved_reg;
reg [31:0] spot_mem [0:SPOT_CHANS-1];

wire acc = wb_cyc_in & wb_stb_in & ~wb_ack_out;
wire wr = acc & wb_we_in;
wire wr_ctrl = wr & (wb_adr_in == `HBS_ADR_CTRL) & wb_sel_in[0];
wire wr_result = wr & (wb_adr_in == `HBS_ADR_RESULT) & wb_sel_in[0];
wire wr_status = wr & (wb_adr_in == `HBS_ADR_STATUS) & wb_sel_in[0];
wire wr_save = wr & (wb_adr_in == `HBS_ADR_SAVE) & wb_sel_in[0];
wire wr_idx = wr & (wb_adr_in == `HBS_ADR_SPOTIDX) & wb_sel_in[0];
wire wr_data = wr & (wb_adr_in == `HBS_ADR_SPOTDATA);
wire init_cmd = wr & (wb_adr_in == `HBS_ADR_CTRL) & wb_sel_in[1]
  & wb_dat_in[`HBS_CTRL_INIT];

// Per-lane merge for partial writes of a spot word
function [31:0] byte_merge;
  input [31:0] old_val;
  input [31:0] new_val;
  input [3:0] sel;
  integer i;
  begin
    byte_merge = old_val;
    for (i = 0; i < 4; i = i + 1) begin
      if (sel[i]) begin
        byte_merge[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
  end
endfunction

////////////////////////////////////////////////////////////////////////
// Input synchronisers

reg [2:0] measure_trigger_input_sync_reg;
reg [1:0] lock_sync_reg;
reg [2:0] strobe_sync_reg;
reg [6:0] sel_s1_reg;
reg [6:0] sel_s2_reg;

always @(posedge core_clk_in) begin
  if (sys_rst_in) begin
    // Idle levels, so no false edge follows reset
    measure_trigger_input_sync_reg <= 3'h0;
    lock_sync_reg <= 2'h3;
    strobe_sync_reg <= 3'h7;
    sel_s1_reg <= 7'h7f;
    sel_s2_reg <= 7'h7f;
  end else begin
    measure_trigger_input_sync_reg <= {measure_trigger_input_sync_reg[1:0], measure_trigger_input_in};
    lock_sync_reg <= {lock_sync_reg[0], key_lock_n_in};
    strobe_sync_reg <= {strobe_sync_reg[1:0], recall_strobe_input_n_in};
    sel_s1_reg <= recall_select_input_n_in;
    sel_s2_reg <= sel_s1_reg;
  end
end

wire measure_trigger_input_rise = measure_trigger_input_sync_reg[1] & ~measure_trigger_input_sync_reg[2];
wire measure_trigger_input_fall = ~measure_trigger_input_sync_reg[1] & measure_trigger_input_sync_reg[2];
wire measure_trigger_input_edge = pol_pos_reg ? measure_trigger_input_rise : measure_trigger_input_fall;
wire strobe_fall = ~strobe_sync_reg[1] & strobe_sync_reg[2];
// Recall code lines are active low
wire [6:0] rcl_code = ~sel_s2_reg;

////////////////////////////////////////////////////////////////////////
// Register file

always @(posedge core_clk_in) begin
  if (sys_rst_in) begin
    comp_en_reg <= 1'b0;
    excl_reg <= 1'b0;
    ext_reg <= 1'b0;
    mode_reg <= `HBS_MODE_SPOT;
    pol_pos_reg <= 1'b1;
    result_reg <= 8'h00;
    spot_idx_reg <= 5'h00;
    saved_reg <= {RCL_LOCS{1'b0}};
  end else begin
    // Initialize leaves the trigger polarity alone
    if (init_cmd) begin
      comp_en_reg <= 1'b0;
      excl_reg <= 1'b0;
      ext_reg <= 1'b0;
      mode_reg <= `HBS_MODE_SPOT;
    end else if (wr_ctrl) begin
      comp_en_reg <= wb_dat_in[`HBS_CTRL_EN];
      excl_reg <= wb_dat_in[`HBS_CTRL_EXCL];
      ext_reg <= wb_dat_in[`HBS_CTRL_EXT];
      mode_reg <= wb_dat_in[`HBS_CTRL_MODE_LO +: 3];
    end
    if (panel_pol_wr_in) begin
      pol_pos_reg <= panel_pol_pos_in;
    end
    if (wr_result) begin
      result_reg <= wb_dat_in[7:0];
    end
    if (wr_idx) begin
      spot_idx_reg <= wb_dat_in[4:0];
    end
    if (wr_save) begin
      saved_reg[wb_dat_in[6:0]] <= wb_dat_in[`HBS_SAVE_VALID];
    end
  end
end

always @(posedge core_clk_in) begin
  if (wr_data) begin
    spot_mem[spot_idx_reg] <= byte_merge(spot_mem[spot_idx_reg], wb_dat_in, wb_sel_in);
  end
end

////////////////////////////////////////////////////////////////////////
// Bus answer

reg [31:0] rd_data;
always @* begin
  case (wb_adr_in)
    `HBS_ADR_CTRL: rd_data = {26'h0, mode_reg, ext_reg, excl_reg, comp_en_reg};
    `HBS_ADR_RESULT: rd_data = {24'h0, result_reg};
    `HBS_ADR_STATUS: rd_data = {20'h0, last_code_reg, rcl_done_reg, rcl_err_reg,
      busy_reg, panel_locked_out, pol_pos_reg};
    `HBS_ADR_SPOTIDX: rd_data = {27'h0, spot_idx_reg};
    `HBS_ADR_SPOTDATA: rd_data = spot_mem[spot_idx_reg];
    default: rd_data = 32'h0;
  endcase
end

always @(posedge core_clk_in) begin
  if (sys_rst_in) begin
    wb_ack_out <= 1'b0;
    wb_dat_out <= 32'h0;
  end else begin
    // Ack stands one cycle; read data is zero outside it
    wb_ack_out <= acc;
    wb_dat_out <= acc & ~wb_we_in ? rd_data : 32'h0;
  end
end

////////////////////////////////////////////////////////////////////////
// Trigger, lock and measurement cycle

always @(posedge core_clk_in) begin
  if (sys_rst_in) begin
    measure_start_out <= 1'b0;
    panel_locked_out <= 1'b0;
    busy_reg <= 1'b0;
  end else begin
    measure_start_out <= measure_trigger_input_edge;
    panel_locked_out <= ~lock_sync_reg[1];
    // Busy from trigger edge to result write; the edge wins
    if (measure_trigger_input_edge) begin
      busy_reg <= 1'b1;
    end else if (wr_result) begin
      busy_reg <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Sorting outputs

wire [3:0] res_bin = result_reg[3:0];
wire res_err = result_reg[`HBS_RES_ERR];
wire res_sng = result_reg[`HBS_RES_SNG];
wire [3:0] max_bin = ext_reg ? `HBS_EXT_BINS : `HBS_BASE_BINS;
// Class zero or above the limit counts as out of range
wire bin_ok = (res_bin != 4'h0) && (res_bin <= max_bin);
wire prim_out = ~bin_ok;

reg [13:0] bins_n;
reg rej_n;
reg sng_n;
reg phi_n;
reg plo_n;
integer k;
always @* begin
  bins_n = 14'h3fff;
  for (k = 0; k < 14; k = k + 1) begin
    if (bin_ok && (res_bin == k + 1)) begin
      bins_n[k] = 1'b0;
    end
  end
  // A secondary failure never leaves a class asserted
  if (res_sng) begin
    bins_n = 14'h3fff;
  end
  rej_n = ~(prim_out | (res_sng & ~excl_reg));
  sng_n = ~res_sng;
  phi_n = ~(~ext_reg & prim_out & result_reg[`HBS_RES_PHI]);
  plo_n = ~(~ext_reg & prim_out & result_reg[`HBS_RES_PLO]);
  if (res_err) begin
    bins_n = 14'h3fff;
    rej_n = 1'b1;
    sng_n = 1'b1;
    phi_n = 1'b1;
    plo_n = 1'b1;
  end
end

always @(posedge core_clk_in) begin
  if (sys_rst_in || !comp_en_reg) begin
    bin_class_output_n_out <= 14'h3fff;
    reject_output_n_out <= 1'b1;
    secondary_fail_output_n_out <= 1'b1;
    error_output_n_out <= 1'b1;
    primary_high_output_n_out <= 1'b1;
    primary_low_output_n_out <= 1'b1;
    measurement_done_output_n_out <= 1'b0;
    index_output_n_out <= 1'b0;
  end else begin
    // Results hold while busy; only forced blanks change then
    measurement_done_output_n_out <= busy_reg;
    index_output_n_out <= busy_reg;
    if (wr_result) begin
      bin_class_output_n_out <= 14'h3fff;
      reject_output_n_out <= 1'b1;
      secondary_fail_output_n_out <= 1'b1;
      error_output_n_out <= 1'b1;
      primary_high_output_n_out <= 1'b1;
      primary_low_output_n_out <= 1'b1;
    end else if (!busy_reg) begin
      bin_class_output_n_out <= bins_n;
      reject_output_n_out <= rej_n;
      secondary_fail_output_n_out <= sng_n;
      error_output_n_out <= ~res_err;
      primary_high_output_n_out <= phi_n;
      primary_low_output_n_out <= plo_n;
    end else if (ext_reg) begin
      // Extension switched on while a result is held
      primary_high_output_n_out <= 1'b1;
      primary_low_output_n_out <= 1'b1;
    end else begin
      bin_class_output_n_out[13:9] <= 5'h1f;
    end
  end
end

////////////////////////////////////////////////////////////////////////
// Recall from handler

wire rcl_empty = ~saved_reg[rcl_code];
wire clr_err = wr_status & wb_dat_in[`HBS_ST_ERR];
wire clr_done = wr_status & wb_dat_in[`HBS_ST_DONE];

always @(posedge core_clk_in) begin
  if (sys_rst_in) begin
    rcl_err_reg <= 1'b0;
    rcl_done_reg <= 1'b0;
    last_code_reg <= 7'h00;
    recall_pulse_out <= 1'b0;
    recall_code_out <= 7'h00;
    restore_spot_out <= 1'b0;
    restore_main_out <= 1'b0;
    restore_settings_out <= 1'b0;
    restore_corr_out <= 1'b0;
    keep_corr_state_out <= 1'b0;
    recall_spot_data_out <= 32'h0;
  end else begin
    recall_pulse_out <= strobe_fall & ~rcl_empty;
    // Set wins over a clear in the same cycle
    if (strobe_fall && rcl_empty) begin
      rcl_err_reg <= 1'b1;
    end else if (clr_err) begin
      rcl_err_reg <= 1'b0;
    end
    if (strobe_fall && !rcl_empty) begin
      rcl_done_reg <= 1'b1;
    end else if (clr_done) begin
      rcl_done_reg <= 1'b0;
    end
    if (strobe_fall) begin
      last_code_reg <= rcl_code;
    end
    if (strobe_fall && !rcl_empty) begin
      recall_code_out <= rcl_code;
      recall_spot_data_out <= spot_mem[rcl_code[4:0]];
      restore_spot_out <= 1'b0;
      restore_main_out <= 1'b0;
      restore_settings_out <= 1'b0;
      restore_corr_out <= 1'b0;
      keep_corr_state_out <= 1'b0;
      // Restore scope follows the recall mode
      case (mode_reg)
        `HBS_MODE_SPOT: begin
          restore_spot_out <= 1'b1;
        end
        `HBS_MODE_PARTIAL: begin
          restore_spot_out <= 1'b1;
          restore_main_out <= 1'b1;
          keep_corr_state_out <= 1'b1;
        end
        `HBS_MODE_SETTING: begin
          restore_settings_out <= 1'b1;
        end
        `HBS_MODE_CORR: begin
          restore_corr_out <= 1'b1;
        end
        `HBS_MODE_BOTH: begin
          restore_settings_out <= 1'b1;
          restore_corr_out <= 1'b1;
        end
        default: begin
          restore_spot_out <= 1'b1;
        end
      endcase
    end
  end
end

endmodule

// >>> sim/hbs_handler_io_bench.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_errors++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, got, exp); end end
module hbs_handler_io_bench;
  logic core_clk_in, sys_rst_in, wb_cyc_in, wb_stb_in, wb_we_in, wb_ack_out;
  logic [7:2] wb_adr_in;
  logic [3:0] wb_sel_in;
  logic [31:0] wb_dat_in, wb_dat_out, rd, recall_spot_data_out;
  logic panel_pol_wr_in, panel_pol_pos_in, measure_trigger_input_in, key_lock_n_in;
  logic [6:0] recall_select_input_n_in, recall_code_out;
  logic recall_strobe_input_n_in, reject_output_n_out, secondary_fail_output_n_out;
  logic error_output_n_out, primary_high_output_n_out, primary_low_output_n_out;
  logic measurement_done_output_n_out, index_output_n_out, measure_start_out;
  logic panel_locked_out, recall_pulse_out, restore_spot_out, restore_main_out;
  logic restore_settings_out, restore_corr_out, keep_corr_state_out;
  logic [13:0] bin_class_output_n_out;
  logic [18:0] v;
  wire [18:0] sort_n = {error_output_n_out, primary_high_output_n_out, primary_low_output_n_out,
    secondary_fail_output_n_out, reject_output_n_out, bin_class_output_n_out};
  int n_errors, checks_done, n_starts, n;
  typedef struct packed {logic [7:0] ctl; logic [7:0] res; logic [18:0] act;} hbs_row_t;
  // Control, result, active outputs {err,high,low,sfail,reject,classes}
  hbs_row_t rows [9] = '{'{8'h05, 8'h0e, 19'h02000}, '{8'h05, 8'h20, 19'h04000},
    '{8'h01, 8'h03, 19'h00004}, '{8'h01, 8'h09, 19'h00100}, '{8'h01, 8'h1c, 19'h24000},
    '{8'h01, 8'h43, 19'h0c000}, '{8'h03, 8'h43, 19'h08000}, '{8'h01, 8'hd3, 19'h40000},
    '{8'h01, 8'h2a, 19'h14000}};
  logic [1:0] exp_sc [5] = '{2'b00, 2'b00, 2'b10, 2'b01, 2'b11};
  hbs_handler_io i_dut (
    .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
    .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .panel_pol_wr_in(panel_pol_wr_in), .panel_pol_pos_in(panel_pol_pos_in),
    .measure_trigger_input_in(measure_trigger_input_in), .key_lock_n_in(key_lock_n_in),
    .recall_select_input_n_in(recall_select_input_n_in),
    .recall_strobe_input_n_in(recall_strobe_input_n_in),
    .bin_class_output_n_out(bin_class_output_n_out), .reject_output_n_out(reject_output_n_out),
    .secondary_fail_output_n_out(secondary_fail_output_n_out),
    .error_output_n_out(error_output_n_out),
    .primary_high_output_n_out(primary_high_output_n_out),
    .primary_low_output_n_out(primary_low_output_n_out),
    .measurement_done_output_n_out(measurement_done_output_n_out),
    .index_output_n_out(index_output_n_out), .measure_start_out(measure_start_out),
    .panel_locked_out(panel_locked_out), .recall_pulse_out(recall_pulse_out),
    .recall_code_out(recall_code_out), .restore_spot_out(restore_spot_out),
    .restore_main_out(restore_main_out), .restore_settings_out(restore_settings_out),
    .restore_corr_out(restore_corr_out), .keep_corr_state_out(keep_corr_state_out),
    .recall_spot_data_out(recall_spot_data_out)
  );
  hbs_handler_model i_hnd (
    .core_clk_in(core_clk_in),
    .measure_trigger_input_out(measure_trigger_input_in),
    .lock_n_out(key_lock_n_in),
    .code_n_out(recall_select_input_n_in),
    .strobe_n_out(recall_strobe_input_n_in),
    .done_n_in(measurement_done_output_n_out),
    .sort_n_in(sort_n)
  );
  always #10 core_clk_in = ~core_clk_in;
  always @(posedge core_clk_in) if (measure_start_out === 1'b1) n_starts <= n_starts + 1;
  task automatic wb(input logic we, input logic [5:0] a, input logic [3:0] s,
                    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_adr_in <= a;
    wb_sel_in <= s;
    wb_dat_in <= d;
    do begin
      @(posedge core_clk_in);
      k++;
    end while (wb_ack_out !== 1'b1 && k < 50);
    if (wb_ack_out !== 1'b1) n_errors++;
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
  endtask
  task automatic summarize();
    if (n_errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #100us;
    n_errors++;
    summarize();
  end
  initial begin
    core_clk_in = 1'b0;
    sys_rst_in = 1'b1;
    {wb_cyc_in, wb_stb_in, wb_we_in, panel_pol_wr_in, panel_pol_pos_in} = 5'h00;
    wb_adr_in = 6'h00;
    wb_sel_in = 4'h0;
    wb_dat_in = 32'h0;
    repeat (3) @(posedge core_clk_in);
    sys_rst_in <= 1'b0;
    @(posedge core_clk_in);
    `CHK({sort_n, measurement_done_output_n_out}, 20'hffffe)
    foreach (rows[i]) begin
      wb(1'b1, 6'h00, 4'h1, {24'h0, rows[i].ctl});
      i_hnd.drive(1'b1, 1'b1);
      i_hnd.drive(1'b0, 1'b1);
      wb(1'b1, 6'h01, 4'h1, {24'h0, rows[i].res});
      i_hnd.read_sort(v);
      `CHK(v, ~rows[i].act)
      `CHK(measurement_done_output_n_out, 1'b0)
    end
    // Falling trigger edge only
    panel_pol_wr_in <= 1'b1;
    @(posedge core_clk_in);
    panel_pol_wr_in <= 1'b0;
    n = n_starts;
    i_hnd.drive(1'b1, 1'b1);
    `CHK(n_starts, n)
    i_hnd.drive(1'b0, 1'b0);
    `CHK(n_starts, n + 1)
    wb(1'b1, 6'h00, 4'h3, 32'h100);
    wb(1'b0, 6'h02, 4'hf, 32'h0);
    `CHK(rd[0], 1'b0)
    `CHK({sort_n, measurement_done_output_n_out, panel_locked_out}, 21'h1ffffd)
    wb(1'b1, 6'h03, 4'hf, 32'h105);
    for (int m = 0; m < 5; m++) begin
      wb(1'b1, 6'h00, 4'h1, 32'(m << 3));
      i_hnd.recall(7'h05);
      `CHK({recall_code_out, restore_settings_out, restore_corr_out}, {7'h05, exp_sc[m]})
    end
    i_hnd.recall(7'h09);
    wb(1'b0, 6'h02, 4'hf, 32'h0);
    `CHK(rd[3], 1'b1)
    wb(1'b1, 6'h04, 4'h1, 32'h1f);
    wb(1'b1, 6'h05, 4'hf, 32'h12345678);
    wb(1'b1, 6'h05, 4'h2, 32'h0000ab00);
    wb(1'b1, 6'h03, 4'hf, 32'h11f);
    i_hnd.recall(7'h1f);
    `CHK(recall_spot_data_out, 32'h1234ab78)
    wb(1'b0, 6'h3f, 4'hf, 32'h0);
    `CHK(rd, 32'h0)
    summarize();
  end
endmodule

// >>> sim/hbs_handler_io_checker.sv
`timescale 1ns/100ps
module hbs_handler_io_checker (
  // Clock and reset
  input wire core_clk_in,
  input wire sys_rst_in,
  // Bus and panel
  input wire wb_cyc_in,
  input wire wb_stb_in,
  input wire wb_we_in,
  input wire [7:2] wb_adr_in,
  input wire [3:0] wb_sel_in,
  input wire [31:0] wb_dat_in,
  input wire wb_ack_out,
  input wire panel_pol_wr_in,
  input wire panel_pol_pos_in,
  // Handler side
  input wire measure_trigger_input_in,
  input wire [13:0] bin_class_output_n_out,
  input wire reject_output_n_out,
  input wire secondary_fail_output_n_out,
  input wire error_output_n_out,
  input wire primary_high_output_n_out,
  input wire primary_low_output_n_out,
  input wire measurement_done_output_n_out,
  input wire index_output_n_out,
  // Engine side
  input wire measure_start_out,
  input wire recall_pulse_out,
  input wire restore_spot_out,
  input wire restore_main_out,
  input wire keep_corr_state_out
);
  logic [5:0] ctl_reg, q1_reg, q2_reg;
  logic pol_reg;
  wire wr = wb_cyc_in && wb_stb_in && wb_we_in && !wb_ack_out && wb_adr_in == 6'h00;
  wire off = !ctl_reg[0] && !q1_reg[0] && !q2_reg[0];
  wire ext_on = ctl_reg[2] && q1_reg[2] && q2_reg[2];
  wire ext_off = !ctl_reg[2] && !q1_reg[2] && !q2_reg[2];
  wire measure_trigger_input = measure_trigger_input_in;
  // Shadow of the control word, aged so outputs have settled
  always @(posedge core_clk_in) begin
    if (sys_rst_in || (wr && wb_sel_in[1] && wb_dat_in[8])) ctl_reg <= 6'h00;
    else if (wr && wb_sel_in[0]) ctl_reg <= wb_dat_in[5:0];
    if (sys_rst_in) pol_reg <= 1'b1;
    else if (panel_pol_wr_in) pol_reg <= panel_pol_pos_in;
    q1_reg <= ctl_reg;
    q2_reg <= q1_reg;
  end
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (sys_rst_in);
  a_off_sort_high:
    assert property (off |-> &{bin_class_output_n_out, reject_output_n_out,
      secondary_fail_output_n_out, error_output_n_out}) else $error("output active while off");
  a_off_done_low:
    assert property (off |-> !measurement_done_output_n_out && !index_output_n_out)
    else $error("done or index high while off");
  a_err_blanks_all:
    assert property (!error_output_n_out |-> &{bin_class_output_n_out, reject_output_n_out,
      secondary_fail_output_n_out, primary_high_output_n_out, primary_low_output_n_out})
    else $error("sort output beside error");
  a_ext_no_limits:
    assert property (ext_on |-> primary_high_output_n_out && primary_low_output_n_out)
    else $error("high or low with extension");
  a_base_no_ext:
    assert property (ext_off |-> &bin_class_output_n_out[13:9]) else $error("class above nine");
  a_measure_trigger_input_start:
    assert property ((pol_reg ? $rose(measure_trigger_input) : $fell(measure_trigger_input)) |-> ##3 measure_start_out)
    else $error("trigger edge missed");
  a_start_cause:
    assert property (measure_start_out |-> $past(measure_trigger_input, 3) == pol_reg && $past(measure_trigger_input, 4) != pol_reg)
    else $error("start without edge");
  a_spot_only:
    assert property (recall_pulse_out && ctl_reg[5:3] == 3'h0 |->
      restore_spot_out && !restore_main_out) else $error("spot recall wrong");
  a_partial_keep:
    assert property (recall_pulse_out && ctl_reg[5:3] == 3'h1 |->
      restore_spot_out && restore_main_out && keep_corr_state_out) else $error("partial wrong");
endmodule
bind hbs_handler_io hbs_handler_io_checker i_chk (
  .core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .wb_cyc_in(wb_cyc_in),
  .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
  .wb_dat_in(wb_dat_in), .wb_ack_out(wb_ack_out), .panel_pol_wr_in(panel_pol_wr_in),
  .panel_pol_pos_in(panel_pol_pos_in), .measure_trigger_input_in(measure_trigger_input_in),
  .bin_class_output_n_out(bin_class_output_n_out), .reject_output_n_out(reject_output_n_out),
  .secondary_fail_output_n_out(secondary_fail_output_n_out),
  .error_output_n_out(error_output_n_out),
  .primary_high_output_n_out(primary_high_output_n_out),
  .primary_low_output_n_out(primary_low_output_n_out),
  .measurement_done_output_n_out(measurement_done_output_n_out),
  .index_output_n_out(index_output_n_out), .measure_start_out(measure_start_out),
  .recall_pulse_out(recall_pulse_out), .restore_spot_out(restore_spot_out),
  .restore_main_out(restore_main_out), .keep_corr_state_out(keep_corr_state_out)
);

// >>> sim/hbs_handler_model.sv
`timescale 1ns/100ps
module hbs_handler_model (
  // Clock
  input wire core_clk_in,
  // Handler drives
  output logic measure_trigger_input_out,
  output logic lock_n_out,
  output logic [6:0] code_n_out,
  output logic strobe_n_out,
  // Handler watches
  input wire done_n_in,
  input wire [18:0] sort_n_in
);
  initial begin
    measure_trigger_input_out = 1'b0;
    lock_n_out = 1'b1;
    code_n_out = 7'h7f;
    strobe_n_out = 1'b1;
  end
  task automatic drive(input logic measure_trigger_input, input logic lock_n);
    @(posedge core_clk_in);
    measure_trigger_input_out <= measure_trigger_input;
    lock_n_out <= lock_n;
    repeat (6) @(posedge core_clk_in);
  endtask
  // Code settles before the strobe falls
  task automatic recall(input logic [6:0] code);
    @(posedge core_clk_in);
    code_n_out <= ~code;
    repeat (3) @(posedge core_clk_in);
    strobe_n_out <= 1'b0;
    repeat (6) @(posedge core_clk_in);
    strobe_n_out <= 1'b1;
    repeat (3) @(posedge core_clk_in);
  endtask
  task automatic read_sort(output logic [18:0] v);
    int n;
    n = 0;
    while (done_n_in !== 1'b0 && n < 200) begin
      @(posedge core_clk_in);
      n++;
    end
    repeat (3) @(posedge core_clk_in);
    v = sort_n_in;
  endtask
endmodule
